// ### rtl/sgp_pkg.sv
package sgp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned NPIN = 6;
    localparam int unsigned CH_BIT = 3;
    // register byte addresses
    localparam logic [7:0] ADDR_PIN_DATA = 8'h00;
    localparam logic [7:0] ADDR_DIRECTION = 8'h04;
    localparam logic [7:0] ADDR_ANALOG_SEL = 8'h08;
    localparam logic [7:0] ADDR_PULLUP_EN = 8'h0C;
    localparam logic [7:0] ADDR_CHANGE_EN = 8'h10;
    localparam logic [7:0] ADDR_CONTROL = 8'h14;
    // control register fields
    localparam int unsigned CTL_FLAG_POS = 0;
    localparam int unsigned CTL_GPD_POS = 1;
    localparam int unsigned CTL_OSC_LSB = 2;
    localparam int unsigned CTL_EXTRST_POS = 5;
    // reset values and fixed pin masks
    localparam logic [5:0] RST_DIRECTION = 6'h3F;
    localparam logic [7:0] RST_ANALOG_SEL = 8'hFF;
    localparam logic [5:0] RST_PULLUP_EN = 6'h37;
    localparam logic [5:0] RST_CHANGE_EN = 6'h00;
    localparam logic [5:0] RST_LATCH = 6'h00;
    localparam logic RST_GPD = 1'b1;
    localparam logic RST_EXTRST = 1'b1;
    localparam logic [5:0] XTAL_PIN_MASK = 6'h30;
    localparam logic [5:0] PIN3_MASK = 6'h08;
    typedef enum logic [2:0] {
        SGP_OSC_INTERNAL = 3'b000,
        SGP_OSC_CRYSTAL_LOW_POWER = 3'b001,
        SGP_OSC_CRYSTAL_STANDARD = 3'b010,
        SGP_OSC_CRYSTAL_HIGH_SPEED = 3'b011,
        SGP_OSC_EXTERNAL_RC = 3'b100
    } sgp_osc_e;
endpackage

// ### rtl/sgp_port.sv
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
module sgp_port
    import sgp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic warm_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [5:0] pin_i,
    output logic [5:0] pin_o,
    output logic [5:0] pin_oe_o,
    output logic [5:0] pullup_o,
    output logic [7:0] analog_en_o,
    output logic port_change_flag_o,
    output logic wake_o
);
    logic rst_any;
    logic [5:0] sync_a_reg;
    logic [5:0] sync_b_reg;
    logic [5:0] latch_reg;
    logic [5:0] dir_reg;
    logic [7:0] analog_select_reg;
    logic [5:0] pullup_enable_reg;
    logic [5:0] change_irq_enable_reg;
    logic [5:0] last_read_reg;
    logic global_pullup_disable_reg;
    logic ext_reset_pin_enable_reg;
    sgp_osc_e osc_mode_reg;
    logic flag_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [5:0] oe_reg;
    logic [5:0] pout_reg;
    logic [5:0] pu_reg;
    logic [7:0] an_reg;
    logic wake_reg;
    logic req;
    logic wr_lane0;
    logic port_access;
    logic xtal_mode;
    logic [5:0] xtal_mask;
    logic [5:0] dir_eff;
    logic [5:0] pin_read;
    logic [5:0] mismatch_bits;
    logic mismatch;
    logic [5:0] pu_next;
    logic [31:0] rd_next;
    logic flag_clear;

    assign rst_any = rst_i | warm_rst_i;
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
    assign port_access = req & (wb_adr_i == ADDR_PIN_DATA);
    assign xtal_mode = (osc_mode_reg == SGP_OSC_CRYSTAL_LOW_POWER) |
                       (osc_mode_reg == SGP_OSC_CRYSTAL_STANDARD) |
                       (osc_mode_reg == SGP_OSC_CRYSTAL_HIGH_SPEED);
    assign xtal_mask = xtal_mode ? XTAL_PIN_MASK : 6'h00;
    assign dir_eff = dir_reg | xtal_mask | PIN3_MASK;

    always_ff @(posedge clk_i) begin
        sync_a_reg <= pin_i;
        sync_b_reg <= sync_a_reg;
    end

    // sampled pins gated by analog select
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
            if (gi == CH_BIT) begin : g_in_only
                assign pin_read[gi] = sync_b_reg[gi] & ~analog_select_reg[gi] & ~ext_reset_pin_enable_reg;
                // pull-up tied to reset pin use
                assign pu_next[gi] = ext_reset_pin_enable_reg;
            end else begin : g_io
                assign pin_read[gi] = sync_b_reg[gi] & ~analog_select_reg[gi];
                assign pu_next[gi] = pullup_enable_reg[gi] & ~global_pullup_disable_reg &
                                     dir_eff[gi] & ~analog_select_reg[gi];
            end
            assign mismatch_bits[gi] = change_irq_enable_reg[gi] & ~analog_select_reg[gi] &
                                       (pin_read[gi] ^ last_read_reg[gi]);
        end
    endgenerate
    assign mismatch = |mismatch_bits;
    assign flag_clear = wr_lane0 & (wb_adr_i == ADDR_CONTROL) & wb_dat_i[CTL_FLAG_POS];

    always_comb begin
        rd_next = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_PIN_DATA: rd_next[5:0] = pin_read;
            ADDR_DIRECTION: rd_next[5:0] = dir_eff;
            ADDR_ANALOG_SEL: rd_next[7:0] = analog_select_reg;
            ADDR_PULLUP_EN: rd_next[5:0] = (pullup_enable_reg & ~PIN3_MASK) | xtal_mask;
            ADDR_CHANGE_EN: rd_next[5:0] = change_irq_enable_reg | xtal_mask;
            ADDR_CONTROL: begin
                rd_next[CTL_FLAG_POS] = flag_reg;
                rd_next[CTL_GPD_POS] = global_pullup_disable_reg;
                rd_next[CTL_OSC_LSB +: 3] = osc_mode_reg;
                rd_next[CTL_EXTRST_POS] = ext_reset_pin_enable_reg;
            end
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // single-wait slave; unmapped addresses ack with zero data
    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            if (req) begin
                dat_reg <= rd_next;
            end
        end
    end

    // write lands in the latch only
    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            latch_reg <= RST_LATCH;
        end else if (port_access && wr_lane0) begin
            latch_reg <= wb_dat_i[5:0];
        end
    end

    // only power-on reset clears the last-read latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_read_reg <= RST_LATCH;
        end else if (port_access) begin
            // any port access ends the mismatch
            last_read_reg <= pin_read;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            dir_reg <= RST_DIRECTION;
            analog_select_reg <= RST_ANALOG_SEL;
            pullup_enable_reg <= RST_PULLUP_EN;
            change_irq_enable_reg <= RST_CHANGE_EN;
            global_pullup_disable_reg <= RST_GPD;
            ext_reset_pin_enable_reg <= RST_EXTRST;
            osc_mode_reg <= SGP_OSC_INTERNAL;
        end else if (wr_lane0) begin
            case (wb_adr_i)
                ADDR_DIRECTION: dir_reg <= wb_dat_i[5:0];
                ADDR_ANALOG_SEL: analog_select_reg <= wb_dat_i[7:0];
                ADDR_PULLUP_EN: pullup_enable_reg <= wb_dat_i[5:0];
                ADDR_CHANGE_EN: change_irq_enable_reg <= wb_dat_i[5:0];
                ADDR_CONTROL: begin
                    global_pullup_disable_reg <= wb_dat_i[CTL_GPD_POS];
                    ext_reset_pin_enable_reg <= wb_dat_i[CTL_EXTRST_POS];
                    osc_mode_reg <= sgp_osc_e'(wb_dat_i[CTL_OSC_LSB +: 3]);
                end
                default: osc_mode_reg <= osc_mode_reg;
            endcase
        end
    end

    // flag: set wins over clear, access cycle blinds detection
    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            flag_reg <= 1'b0;
        end else if (mismatch && !port_access) begin
            flag_reg <= 1'b1;
        end else if (flag_clear) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            oe_reg <= 6'h00;
            pout_reg <= 6'h00;
            pu_reg <= 6'h00;
            an_reg <= 8'h00;
            wake_reg <= 1'b0;
        end else begin
            oe_reg <= ~dir_eff;
            pout_reg <= latch_reg;
            pu_reg <= pu_next;
            an_reg <= analog_select_reg;
            wake_reg <= flag_reg;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign pin_o = pout_reg;
    assign pin_oe_o = oe_reg;
    assign pullup_o = pu_reg;
    assign analog_en_o = an_reg;
    assign port_change_flag_o = flag_reg;
    assign wake_o = wake_reg;

    // helper: previous cycle was out of reset
    logic live_reg;
    always_ff @(posedge clk_i) begin
        live_reg <= ~rst_any;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_any);

    a_pin3_never_driven: assert property (!pin_oe_o[CH_BIT] && !pin_o[CH_BIT] || !pin_oe_o[CH_BIT])
        else $error("input only pin driven");

    a_input_oe_off: assert property (live_reg |-> pin_oe_o == ~$past(dir_eff))
        else $error("output enable does not follow direction");

    a_output_from_latch: assert property (live_reg |-> pin_o == $past(latch_reg))
        else $error("pin drive differs from latch");

    a_dir3_reads_one: assert property (req && !wb_we_i && wb_adr_i == ADDR_DIRECTION |=> wb_ack_o && wb_dat_o[3])
        else $error("pin three direction read as zero");

    a_analog_reads_zero: assert property (port_access && !wb_we_i ##1 wb_ack_o |->
        (wb_dat_o[5:0] & $past(analog_select_reg[5:0])) == 6'h00)
        else $error("analog pin read as one");

    a_external_reset_pin_reads_zero: assert property (port_access && ext_reset_pin_enable_reg |=> wb_dat_o[CH_BIT] == 1'b0)
        else $error("reset pin bit read as one");

    a_xtal_dir_one: assert property (req && xtal_mode && wb_adr_i == ADDR_DIRECTION |=> wb_dat_o[5:4] == 2'b11)
        else $error("crystal pins direction read as zero");

    a_pullup_off_output: assert property ((pullup_o & pin_oe_o) == 6'h00)
        else $error("pull-up on while driving");

    a_global_pullup_gate: assert property (live_reg && $past(global_pullup_disable_reg) |->
        (pullup_o & ~PIN3_MASK) == 6'h00)
        else $error("pull-up on while globally disabled");

    a_flag_sets: assert property (mismatch && !port_access |=> flag_reg)
        else $error("mismatch failed to set flag");

    a_flag_wake: assert property (flag_reg |=> wake_o)
        else $error("wake missing after flag");

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    a_ack_follows_req: assert property (req |=>
        wb_ack_o)
        else $error("request not acknowledged");

    a_port_write_latch: assert property (port_access && wr_lane0 |=>
        latch_reg == $past(wb_dat_i[5:0]))
        else $error("port write missed the latch");

    a_port_read_keeps: assert property (port_access && !wb_we_i |=>
        latch_reg == $past(latch_reg))
        else $error("port read changed the latch");

    a_port_write_keeps_dir: assert property (port_access && wb_we_i |=>
        dir_reg == $past(dir_reg) && analog_select_reg == $past(analog_select_reg))
        else $error("port write changed configuration");

    a_last_read_load: assert property (port_access |=>
        last_read_reg == $past(pin_read))
        else $error("port access did not reload last read");

    a_warm_keeps_latch: assert property (disable iff (rst_i) warm_rst_i && !port_access |=>
        last_read_reg == $past(last_read_reg))
        else $error("warm reset altered last read");

    a_por_change_off: assert property ($fell(rst_i) |->
        change_irq_enable_reg == RST_CHANGE_EN && !flag_reg && last_read_reg == RST_LATCH)
        else $error("change detection live after power-on reset");

    a_por_pullups_off: assert property ($fell(rst_i) |->
        global_pullup_disable_reg == RST_GPD && pullup_o == 6'h00)
        else $error("pull-ups live after power-on reset");

    a_pullup_analog_off: assert property ((pullup_o & analog_en_o[5:0] & ~PIN3_MASK)
        == 6'h00)
        else $error("pull-up on an analog pin");

    a_pin3_pullup_auto: assert property (live_reg |->
        pullup_o[CH_BIT] == $past(ext_reset_pin_enable_reg))
        else $error("pin three pull-up does not follow reset pin use");

    a_pullup_needs_enable: assert property (live_reg |->
        (pullup_o & ~PIN3_MASK & ~$past(pullup_enable_reg)) == 6'h00)
        else $error("pull-up on without its enable");

    a_analog_copy: assert property (live_reg |->
        analog_en_o == $past(analog_select_reg))
        else $error("analog enable differs from select");

    a_flag_holds: assert property (flag_reg && !flag_clear |=>
        flag_reg)
        else $error("flag dropped without a clear");

    a_flag_clear_works: assert property (flag_clear && !mismatch |=>
        !flag_reg)
        else $error("flag clear ignored");

    a_flag_needs_cause: assert property ($rose(flag_reg) |->
        $past(mismatch) && !$past(port_access))
        else $error("flag set without a mismatch");

    a_access_no_set: assert property (port_access && !flag_reg |=>
        !flag_reg)
        else $error("flag set during a port access");

    a_wake_follows: assert property (live_reg |->
        wake_o == $past(flag_reg))
        else $error("wake differs from flag");

    a_change_en_gate: assert property (change_irq_enable_reg == 6'h00 && !flag_reg |=>
        !flag_reg)
        else $error("flag set with change detection off");

    a_analog_no_change: assert property ((change_irq_enable_reg & ~analog_select_reg[5:0]) == 6'h00 &&
        !flag_reg |=> !flag_reg)
        else $error("analog pin raised the flag");

    a_drive_analog_pin: assert property (live_reg |-> (pin_oe_o & $past(analog_select_reg[5:0])) ==
        (~$past(dir_eff) & $past(analog_select_reg[5:0])))
        else $error("analog select changed the driver");

    a_sync_two_flops: assert property (sync_b_reg ==
        $past(pin_i, 2))
        else $error("synchroniser depth wrong");

    a_xtal_pins_input: assert property (live_reg && $past(xtal_mode) |->
        (pin_oe_o & XTAL_PIN_MASK) == 6'h00)
        else $error("crystal pin driven");

endmodule

// ### verif/sgp_pin_model.sv
`timescale 1ns/1ns
// board side of the six pads: the device driver wins, then the board, then the pull-up
module sgp_pin_model (
    input wire logic clk_i,
    input wire logic [5:0] drive_i,
    input wire logic [5:0] oe_i,
    input wire logic [5:0] pullup_i,
    input wire logic [5:0] board_lvl_i,
    input wire logic [5:0] board_drv_i,
    output logic [5:0] pad_o
);
    logic [5:0] float_q = 6'h15;
    // a floating pad toggles every cycle so a stale value never reads as a match
    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            if (oe_i[k]) pad_o[k] = drive_i[k];
            else if (board_drv_i[k]) pad_o[k] = board_lvl_i[k];
            else if (pullup_i[k]) pad_o[k] = 1'b1;
            else pad_o[k] = float_q[k];
        end
    end
endmodule

// ### verif/six_bit_gpio_port_with_change_irq_tb.sv
`timescale 1ns/1ns
module six_bit_gpio_port_with_change_irq_tb;
    import sgp_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, warm_rst_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, q;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, wb_dat_o;
    logic wb_ack_o, flag, wake;
    logic [5:0] pin_i, pin_o, pin_oe_o, pullup_o, lvl = 6'h08, drv = 6'h08;
    logic [7:0] analog_en_o;
    int failures = 0, n_compared = 0, cycles = 0;
    always #20 clk_i = ~clk_i;
    sgp_port uut (.clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o),
        .analog_en_o(analog_en_o), .port_change_flag_o(flag), .wake_o(wake));
    sgp_pin_model board (.clk_i(clk_i), .drive_i(pin_o), .oe_i(pin_oe_o), .pullup_i(pullup_o),
        .board_lvl_i(lvl), .board_drv_i(drv), .pad_o(pin_i));
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request held until ack is sampled high at a rising edge; read data taken at that same edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            failures++;
            $display("BAD ack expected 1 seen %b", wb_ack_o);
            complete_run();
        end
        q = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask
    task automatic settle();
        repeat (6) @(negedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        rd_chk("dir_rst", ADDR_DIRECTION, 8'h3F);
        rd_chk("ana_rst", ADDR_ANALOG_SEL, 8'hFF);
        rd_chk("pu_rst", ADDR_PULLUP_EN, 8'h37);
        rd_chk("chg_rst", ADDR_CHANGE_EN, 8'h00);
        rd_chk("ctl_rst", ADDR_CONTROL, 8'h22);
        rd_chk("unmapped", 8'h18, 8'h00);
        chk("pullup_rst", 8'h08, {2'b00, pullup_o});
        xfer(1'b1, ADDR_ANALOG_SEL, 8'h00);
        xfer(1'b1, ADDR_DIRECTION, 8'h00);
        xfer(1'b1, ADDR_PIN_DATA, 8'h2A);
        settle();
        rd_chk("dir_pin3", ADDR_DIRECTION, 8'h08);
        chk("oe_out", 8'h37, {2'b00, pin_oe_o});
        chk("drive", 8'h22, {2'b00, pin_o & 6'h37});
        rd_chk("port_rd", ADDR_PIN_DATA, 8'h22);
        xfer(1'b1, ADDR_ANALOG_SEL, 8'h01);
        xfer(1'b1, ADDR_PIN_DATA, 8'h3F);
        settle();
        chk("ana_oe", 8'h37, {2'b00, pin_oe_o});
        chk("ana_drive", 8'h37, {2'b00, pin_o & 6'h37});
        chk("ana_copy", 8'h01, analog_en_o);
        rd_chk("ana_rd", ADDR_PIN_DATA, 8'h36);
        // low power, standard and high speed pin 5:4 direction; RC leaves it alone
        for (int m = 1; m < 5; m++) begin
            xfer(1'b1, ADDR_CONTROL, 8'h22 | 8'(m << 2));
            rd_chk("xtal_dir", ADDR_DIRECTION, (m < 4) ? 8'h38 : 8'h08);
        end
        drv <= 6'h3F;
        lvl <= 6'h00;
        xfer(1'b1, ADDR_DIRECTION, 8'h3F);
        xfer(1'b1, ADDR_ANALOG_SEL, 8'h00);
        xfer(1'b1, ADDR_CONTROL, 8'h20);
        settle();
        chk("pu_global", 8'h3F, {2'b00, pullup_o});
        xfer(1'b1, ADDR_DIRECTION, 8'h3E);
        settle();
        chk("pu_output", 8'h3E, {2'b00, pullup_o});
        xfer(1'b1, ADDR_ANALOG_SEL, 8'h02);
        settle();
        chk("pu_analog", 8'h3C, {2'b00, pullup_o});
        xfer(1'b1, ADDR_CONTROL, 8'h00);
        settle();
        chk("pu_pin3", 8'h34, {2'b00, pullup_o});
        xfer(1'b1, ADDR_DIRECTION, 8'h3F);
        xfer(1'b1, ADDR_ANALOG_SEL, 8'h00);
        lvl <= 6'h08;
        settle();
        rd_chk("port_in", ADDR_PIN_DATA, 8'h08);
        xfer(1'b1, ADDR_CHANGE_EN, 8'h01);
        lvl <= 6'h0C;
        settle();
        chk("flag_off_pin", 8'h00, {7'h0, flag});
        @(posedge clk_i);
        lvl <= 6'h0D;
        settle();
        chk("flag_set", 8'h01, {7'h0, flag});
        chk("wake", 8'h01, {7'h0, wake});
        xfer(1'b1, ADDR_CONTROL, 8'h01);
        settle();
        chk("flag_persist", 8'h01, {7'h0, flag});
        rd_chk("port_end", ADDR_PIN_DATA, 8'h0D);
        xfer(1'b1, ADDR_CONTROL, 8'h01);
        settle();
        chk("flag_clr", 8'h00, {7'h0, flag});
        // the kept latch holds bit0 high, a power-on reset would have cleared it
        @(posedge clk_i);
        lvl <= 6'h0C;
        warm_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        warm_rst_i <= 1'b0;
        xfer(1'b1, ADDR_ANALOG_SEL, 8'h00);
        xfer(1'b1, ADDR_CHANGE_EN, 8'h01);
        settle();
        chk("flag_warm", 8'h01, {7'h0, flag});
        complete_run();
    end
endmodule
